// ### core/adcst_pkg.sv
package adcst_pkg;
   // Register indices; byte address is four times the index
   localparam logic [31:0] OFS_SCAN0 = 32'hFFFF_F200;
   localparam logic [31:0] OFS_TIME0 = 32'hFFFF_F202;
   localparam logic [31:0] OFS_DET0 = 32'hFFFF_F204;
   localparam logic [31:0] OFS_RES0 = 32'hFFFF_F210;
   localparam logic [31:0] OFS_SCAN1 = 32'hFFFF_F240;
   localparam logic [31:0] OFS_TIME1 = 32'hFFFF_F242;
   localparam logic [31:0] OFS_DET1 = 32'hFFFF_F244;
   localparam logic [31:0] OFS_RES1 = 32'hFFFF_F250;
   localparam logic [31:0] OFS_TSEL_A = 32'hFFFF_F280;
   localparam logic [31:0] OFS_TSEL_B = 32'hFFFF_F288;
   localparam int IDX_W = 10;

   localparam logic [15:0] SCAN_RST = 16'h0000;
   localparam logic [15:0] TIME_RST = 16'h0000;
   localparam logic [15:0] DET_RST = 16'h0000;
   localparam logic [7:0] TSEL_RST = 8'h00;
   localparam logic [15:0] SCAN_WMASK = 16'h9FFF;
   localparam logic [15:0] TIME_WMASK = 16'h0700;
   localparam logic [15:0] DET_WMASK = 16'hFFFF;
   localparam logic [7:0] TSEL_A_WMASK = 8'hFF;
   localparam logic [7:0] TSEL_B_WMASK = 8'h33;

   localparam int CE_BIT = 15;
   localparam int CS_BIT = 14;
   localparam int MS_BIT = 12;
   localparam int PLM_BIT = 11;
   localparam int TRG_LSB = 8;
   localparam int SANI_LSB = 4;
   localparam int ANIS_LSB = 0;
   localparam int FR_LSB = 8;
   localparam int DETEN_BIT = 15;
   localparam int DETLH_BIT = 14;
   localparam int DETCH_LSB = 10;
   localparam int DETREF_LSB = 0;

   localparam logic [2:0] TRG_SW = 3'h0;
   localparam logic [2:0] TRG_EXT = 3'h1;
   localparam logic [2:0] TRG_TMR = 3'h2;

   // Busy reads low for six periods of fxx/2; sys_clk is fxx
   localparam int BUSY_LOW_HALF_PERIODS = 6;
   localparam int FXX_DIV = 2;
   localparam logic [8:0] BUSY_LOW_CYC = 9'(BUSY_LOW_HALF_PERIODS * FXX_DIV);
   localparam int SAR_BITS = 10;
   localparam logic [1:0] SAR_STEP_LAST = 2'h3;
   localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
   localparam logic [3:0] SAR_STEPS = 4'hA;
   // Prohibited code 7 runs at the slowest rate
   localparam logic [8:0] CONV_CLK [0:7] = '{9'h158, 9'h0F8, 9'h0B0, 9'h080,
                                             9'h068, 9'h050, 9'h038, 9'h158};

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMP = 2'b01,
      ST_CONV = 2'b11
   } adcst_state_t;

   function automatic logic [15:0] adcst_merge16(input logic [15:0] old, input logic [15:0] wd,
                                                 input logic [1:0] strb, input logic [15:0] mask);
      logic [15:0] be;
      be = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      return (old & ~be) | (wd & be);
   endfunction
endpackage

// ### core/adcst_rmem_if.sv
`timescale 1ns/1ps
interface adcst_rmem_if #(parameter int W = 10, parameter int D = 8);
   logic we;
   logic [$clog2(D)-1:0] waddr;
   logic [W-1:0] wdata;
   logic [$clog2(D)-1:0] raddr;
   logic [W-1:0] rdata;
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
   modport user (output we, output waddr, output wdata, output raddr, input rdata);
endinterface

// ### core/adcst_rmem.sv
`timescale 1ns/1ps
module adcst_rmem #(
   parameter int W = 10,
   parameter int D = 8
) (
   input wire logic sys_clk,   // System clock
   input wire logic rst_b,     // Async reset, active low
   adcst_rmem_if.mem port      // Write from sequencer, read from bus
);
   logic [W-1:0] mem_r [D];
   logic [W-1:0] rdata_r;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < D; i++) begin
            mem_r[i] <= '0;
         end
         rdata_r <= '0;
      end else begin
         if (port.we) begin
            mem_r[port.waddr] <= port.wdata;
         end
         rdata_r <= mem_r[port.raddr];
      end
   end

   assign port.rdata = rdata_r;
endmodule

// ### core/adcst_trig_sel.sv
`timescale 1ns/1ps
module adcst_trig_sel (
   input wire logic [2:0] grp_sel,   // Source group for this converter
   input wire logic cmp_alt,         // Second compare of first timer pair
   input wire logic ovf_alt,         // Second overflow source
   input wire logic [1:0] sel_b,     // Choice within second compare pair
   input wire logic [1:0] sel_c,     // Choice within third compare pair
   input wire logic [5:0] cmp_evt,   // Timer compare event pulses
   input wire logic [1:0] ovf_evt,   // Timer overflow event pulses
   output logic trig                 // Selected trigger pulse
);
   logic a_cmp;
   logic a_ovf;
   logic b_evt;
   logic c_evt;

   assign a_cmp = cmp_alt ? cmp_evt[3] : cmp_evt[0];
   assign a_ovf = ovf_alt ? ovf_evt[1] : ovf_evt[0];
   assign b_evt = sel_b[1] ? (cmp_evt[1] | cmp_evt[2]) : (sel_b[0] ? cmp_evt[2] : cmp_evt[1]);
   assign c_evt = sel_c[1] ? (cmp_evt[4] | cmp_evt[5]) : (sel_c[0] ? cmp_evt[5] : cmp_evt[4]);

   always_comb begin
      case (grp_sel)
         3'h0: trig = a_cmp;
         3'h1: trig = a_ovf;
         3'h2, 3'h3: trig = a_cmp | a_ovf;
         3'h4: trig = b_evt;
         3'h5: trig = c_evt;
         default: trig = a_cmp | a_ovf | b_evt | c_evt;
      endcase
   end
endmodule

// ### core/adcst_top.sv
// Notes on behaviour
// - Timer mode uses events chosen by selectors
// - Scan control written as word or bytes
// - Scan control write mid-conversion restarts sequence if enable stays set
// - Bit 14 reads converter operating status
// - Busy low twelve clocks after each start
// - Bits 6..4 give scan first channel
// - Low bits give single or last channel
// - Time register bits 10..8 writable, all other bits read-only
// - Time register write terminates running conversion
// - Time code sets clocks per conversion
// - Detection compares result with reference value
// - Detection register write terminates running conversion
// - Detection register written as word or bytes
// - Four trigger modes supported
// - Result stored per channel, interrupt at end
// - Result reads have upper six bits zero
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module adcst_top
   import adcst_pkg::*;
#(
   parameter int CONV0_NCH = 6,
   parameter int CONV1_NCH = 8
) (
   input wire logic sys_clk,                   // System clock, 25 MHz
   input wire logic rst_b,                     // Async reset, active low
   input wire logic psel,                      // APB select
   input wire logic penable,                   // APB enable
   input wire logic pwrite,                    // APB direction
   input wire logic [11:0] paddr,              // APB byte address
   input wire logic [31:0] pwdata,             // APB write data
   input wire logic [3:0] pstrb,               // APB byte strobes
   output logic [31:0] prdata,                 // APB read data
   output logic pready,                        // APB ready
   output logic pslverr,                       // APB error on unmapped address
   input wire logic [5:0] timer_compare_event, // Compare pulses, same clock
   input wire logic [1:0] timer_overflow_event,// Overflow pulses, same clock
   input wire logic [1:0] ext_trig_pin,        // External trigger pins
   input wire logic [1:0] ana_cmp_in,          // Comparator: input at or above DAC
   output logic [1:0][2:0] ana_ch_sel,         // Multiplexer channel per converter
   output logic [1:0] ana_sample,              // Sample-hold tracking
   output logic [1:0][9:0] dac_code,           // DAC trial code
   output logic [1:0] conversion_done_irq,     // Sequence end pulse
   output logic [1:0] voltage_detect_irq       // Detection hit pulse
);
   localparam logic [IDX_W-1:0] I_SCAN0 = OFS_SCAN0[IDX_W-1:0];
   localparam logic [IDX_W-1:0] I_SCAN1 = OFS_SCAN1[IDX_W-1:0];
   localparam logic [IDX_W-1:0] I_TIME0 = OFS_TIME0[IDX_W-1:0];
   localparam logic [IDX_W-1:0] I_TIME1 = OFS_TIME1[IDX_W-1:0];
   localparam logic [IDX_W-1:0] I_DET0 = OFS_DET0[IDX_W-1:0];
   localparam logic [IDX_W-1:0] I_DET1 = OFS_DET1[IDX_W-1:0];
   localparam logic [IDX_W-1:0] I_RES0 = OFS_RES0[IDX_W-1:0];
   localparam logic [IDX_W-1:0] I_RES1 = OFS_RES1[IDX_W-1:0];
   localparam logic [IDX_W-1:0] I_TSA = OFS_TSEL_A[IDX_W-1:0];
   localparam logic [IDX_W-1:0] I_TSB = OFS_TSEL_B[IDX_W-1:0];

   logic [15:0] scan_r [2];
   logic [15:0] time_r [2];
   logic [15:0] det_r [2];
   logic [15:0] scan_nxt [2];
   logic [7:0] tsel_a_r;
   logic [7:0] tsel_b_r;
   logic [1:0] wr_scan;
   logic [1:0] wr_time;
   logic [1:0] wr_det;
   logic [1:0] busy;
   logic [9:0] res_rd [2];
   logic [31:0] prdata_r;
   logic ack_r;

   wire [IDX_W-1:0] idx = paddr[11:2];
   wire hit_scan0 = (idx == I_SCAN0);
   wire hit_scan1 = (idx == I_SCAN1);
   wire hit_time0 = (idx == I_TIME0);
   wire hit_time1 = (idx == I_TIME1);
   wire hit_det0 = (idx == I_DET0);
   wire hit_det1 = (idx == I_DET1);
   wire hit_tsa = (idx == I_TSA);
   wire hit_tsb = (idx == I_TSB);
   wire hit_res0 = (idx[9:4] == I_RES0[9:4]) && !idx[0] && (32'(idx[3:1]) < CONV0_NCH);
   wire hit_res1 = (idx[9:4] == I_RES1[9:4]) && !idx[0] && (32'(idx[3:1]) < CONV1_NCH);
   wire hit_any = hit_scan0 | hit_scan1 | hit_time0 | hit_time1 | hit_det0 | hit_det1 |
                  hit_tsa | hit_tsb | hit_res0 | hit_res1;
   wire wr_ok = pready && pwrite && hit_any;

   // One wait state so result memory reads can be registered
   assign pready = psel & penable & ack_r;
   assign pslverr = pready & ~hit_any;
   assign prdata = prdata_r;

   assign wr_scan = {wr_ok & hit_scan1, wr_ok & hit_scan0};
   assign wr_time = {wr_ok & hit_time1, wr_ok & hit_time0};
   assign wr_det = {wr_ok & hit_det1, wr_ok & hit_det0};
   assign scan_nxt[0] = adcst_merge16(scan_r[0], pwdata[15:0], pstrb[1:0], SCAN_WMASK);
   assign scan_nxt[1] = adcst_merge16(scan_r[1], pwdata[15:0], pstrb[1:0], SCAN_WMASK);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= psel & penable & ~ack_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         scan_r[0] <= SCAN_RST;
         scan_r[1] <= SCAN_RST;
         time_r[0] <= TIME_RST;
         time_r[1] <= TIME_RST;
         det_r[0] <= DET_RST;
         det_r[1] <= DET_RST;
         tsel_a_r <= TSEL_RST;
         tsel_b_r <= TSEL_RST;
      end else begin
         for (int g = 0; g < 2; g++) begin
            if (wr_scan[g]) begin
               scan_r[g] <= scan_nxt[g];
            end
            if (wr_time[g]) begin
               time_r[g] <= adcst_merge16(time_r[g], pwdata[15:0], pstrb[1:0], TIME_WMASK);
            end
            if (wr_det[g]) begin
               det_r[g] <= adcst_merge16(det_r[g], pwdata[15:0], pstrb[1:0], DET_WMASK);
            end
         end
         if (wr_ok && hit_tsa && pstrb[0]) begin
            tsel_a_r <= pwdata[7:0] & TSEL_A_WMASK;
         end
         if (wr_ok && hit_tsb && pstrb[0]) begin
            tsel_b_r <= pwdata[7:0] & TSEL_B_WMASK;
         end
      end
   end

   logic [15:0] rd_mux;
   always_comb begin
      if (hit_scan0) begin
         rd_mux = {scan_r[0][15], busy[0], scan_r[0][13:0]};
      end else if (hit_scan1) begin
         rd_mux = {scan_r[1][15], busy[1], scan_r[1][13:0]};
      end else if (hit_time0) begin
         rd_mux = time_r[0];
      end else if (hit_time1) begin
         rd_mux = time_r[1];
      end else if (hit_det0) begin
         rd_mux = det_r[0];
      end else if (hit_det1) begin
         rd_mux = det_r[1];
      end else if (hit_tsa) begin
         rd_mux = {8'h00, tsel_a_r};
      end else if (hit_tsb) begin
         rd_mux = {8'h00, tsel_b_r};
      end else if (hit_res0) begin
         rd_mux = {6'h00, res_rd[0]};
      end else if (hit_res1) begin
         rd_mux = {6'h00, res_rd[1]};
      end else begin
         rd_mux = 16'h0000;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && penable && !ack_r) begin
         prdata_r <= {16'h0000, rd_mux};
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_conv
      adcst_rmem_if #(.W(SAR_BITS), .D(8)) rmem_bus ();
      adcst_state_t st_r;
      adcst_state_t st_nxt;
      logic [2:0] ch_r, ch_nxt;
      logic [8:0] cyc_r, cyc_nxt;
      logic [9:0] sar_r, sar_nxt;
      logic [3:0] left_r, left_nxt;
      logic [1:0] step_r, step_nxt;
      logic ext_s1, ext_s2, ext_s3, cmp_s1, cmp_s2;
      logic tmr_trig, start_evt, done, last_conv, restart, abort, det_hit;
      logic done_irq_r, det_irq_r;
      logic [3:0] pos;

      wire ce = scan_r[g][CE_BIT];
      wire sel_mode = scan_r[g][MS_BIT];
      wire plm = scan_r[g][PLM_BIT];
      wire [2:0] trg = scan_r[g][TRG_LSB +: 3];
      wire [2:0] first_sc = scan_r[g][SANI_LSB +: 3];
      wire [2:0] last_ch = scan_r[g][ANIS_LSB +: 3];
      wire [2:0] first_ch = sel_mode ? last_ch : first_sc;
      wire [8:0] conv_len = CONV_CLK[time_r[g][FR_LSB +: 3]];
      wire ext_edge = ext_s2 & ~ext_s3;
      wire nxt_ce = scan_nxt[g][CE_BIT];
      wire nxt_sw = !scan_nxt[g][PLM_BIT] && (scan_nxt[g][TRG_LSB +: 3] == TRG_SW);

      adcst_trig_sel u_tsel (
         .grp_sel(tsel_a_r[4*g+1 +: 3]),
         .cmp_alt(tsel_a_r[0]),
         .ovf_alt(tsel_a_r[4]),
         .sel_b(tsel_b_r[1:0]),
         .sel_c(tsel_b_r[5:4]),
         .cmp_evt(timer_compare_event),
         .ovf_evt(timer_overflow_event),
         .trig(tmr_trig)
      );

      adcst_rmem #(.W(SAR_BITS), .D(8)) u_rmem (
         .sys_clk(sys_clk),
         .rst_b(rst_b),
         .port(rmem_bus.mem)
      );

      // Polling repeats on its own; timer and pin modes wait for their event
      assign start_evt = ce && (plm ? 1'b1 :
                                (trg == TRG_TMR) ? tmr_trig :
                                (trg == TRG_EXT) ? ext_edge : 1'b0);
      // A scan control write with enable set restarts a running sequence; in software mode it also starts from idle
      assign restart = wr_scan[g] && nxt_ce && ((st_r != ST_IDLE) || nxt_sw);
      assign abort = (wr_scan[g] && !nxt_ce) || wr_time[g] || wr_det[g];
      assign pos = left_r - 4'h1;
      assign last_conv = sel_mode || (ch_r >= last_ch);
      assign busy[g] = (st_r == ST_CONV);

      always_comb begin
         st_nxt = st_r;
         ch_nxt = ch_r;
         cyc_nxt = cyc_r;
         sar_nxt = sar_r;
         left_nxt = left_r;
         step_nxt = step_r;
         done = 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (start_evt) begin
                  st_nxt = ST_SAMP;
                  ch_nxt = first_ch;
                  cyc_nxt = 9'h000;
               end
            end
            ST_SAMP: begin
               cyc_nxt = cyc_r + 9'h001;
               if (cyc_r == BUSY_LOW_CYC - 9'h001) begin
                  st_nxt = ST_CONV;
                  sar_nxt = SAR_FIRST_TRIAL;
                  left_nxt = SAR_STEPS;
                  step_nxt = 2'h0;
               end
            end
            ST_CONV: begin
               cyc_nxt = cyc_r + 9'h001;
               step_nxt = step_r + 2'h1;
               if (step_r == SAR_STEP_LAST && left_r != 4'h0) begin
                  if (!cmp_s2) begin
                     sar_nxt[pos] = 1'b0;
                  end
                  if (pos != 4'h0) begin
                     sar_nxt[pos - 4'h1] = 1'b1;
                  end
                  left_nxt = left_r - 4'h1;
               end
               if (cyc_r == conv_len - 9'h001) begin
                  done = 1'b1;
                  cyc_nxt = 9'h000;
                  if (last_conv) begin
                     st_nxt = ST_IDLE;
                  end else begin
                     st_nxt = ST_SAMP;
                     ch_nxt = ch_r + 3'h1;
                  end
               end
            end
            default: st_nxt = ST_IDLE;
         endcase
         if (restart) begin
            st_nxt = ST_SAMP;
            ch_nxt = scan_nxt[g][MS_BIT] ? scan_nxt[g][ANIS_LSB +: 3] : scan_nxt[g][SANI_LSB +: 3];
            cyc_nxt = 9'h000;
         end else if (abort) begin
            st_nxt = ST_IDLE;
            done = 1'b0;
         end
      end

      assign det_hit = det_r[g][DETEN_BIT] && (ch_r == det_r[g][DETCH_LSB +: 3]) &&
                       (det_r[g][DETLH_BIT] ? (sar_r > det_r[g][DETREF_LSB +: 10]) :
                                              (sar_r < det_r[g][DETREF_LSB +: 10]));

      assign rmem_bus.we = done;
      assign rmem_bus.waddr = ch_r;
      assign rmem_bus.wdata = sar_r;
      assign rmem_bus.raddr = idx[3:1];
      assign res_rd[g] = rmem_bus.rdata;

      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            st_r <= ST_IDLE;
            ch_r <= 3'h0;
            cyc_r <= 9'h000;
            sar_r <= 10'h000;
            left_r <= 4'h0;
            step_r <= 2'h0;
            done_irq_r <= 1'b0;
            det_irq_r <= 1'b0;
         end else begin
            st_r <= st_nxt;
            ch_r <= ch_nxt;
            cyc_r <= cyc_nxt;
            sar_r <= sar_nxt;
            left_r <= left_nxt;
            step_r <= step_nxt;
            done_irq_r <= done && last_conv;
            det_irq_r <= done && det_hit;
         end
      end

      // Asynchronous pins, two flops deep
      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
         end else begin
            ext_s1 <= ext_trig_pin[g];
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            cmp_s1 <= ana_cmp_in[g];
            cmp_s2 <= cmp_s1;
         end
      end

      assign ana_ch_sel[g] = ch_r;
      assign ana_sample[g] = (st_r == ST_SAMP);
      assign dac_code[g] = sar_r;
      assign conversion_done_irq[g] = done_irq_r;
      assign voltage_detect_irq[g] = det_irq_r;
   end
endmodule

// ### verif/adcst_chk.sv
`timescale 1ns/1ps
module adcst_chk (
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic [1:0][2:0] ana_ch_sel, // Channel
   input wire logic [1:0] ana_sample, // Sampling
   input wire logic [1:0] conversion_done_irq, // Done
   input wire logic [1:0] voltage_detect_irq // Detect
);
   logic [1:0][4:0] smp_r;
   logic [1:0][5:0] gap_r;
   logic wacc_r;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Writes may cut a sample phase short
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         smp_r <= '0;
         gap_r <= '1;
         wacc_r <= 1'b0;
      end else begin
         wacc_r <= psel && penable && pwrite && pready;
         for (int k = 0; k < 2; k++) begin
            smp_r[k] <= ana_sample[k] ? smp_r[k] + 5'h1 : 5'h0;
            gap_r[k] <= conversion_done_irq[k] ? 6'h0 : gap_r[k] + 6'(gap_r[k] != 6'h3F);
         end
      end
   end
   AST_APB_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("no wait state");
   AST_ERR_UNMAPPED: assert property (pready && paddr == 12'hFFC |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped accepted");
   AST_SAMP0: assert property ($fell(ana_sample[0]) && !wacc_r |-> smp_r[0] == 5'hC)
      else $error("sample length 0");
   AST_SAMP1: assert property ($fell(ana_sample[1]) && !wacc_r |-> smp_r[1] == 5'hC)
      else $error("sample length 1");
   AST_DONE_GAP0: assert property (conversion_done_irq[0] |-> gap_r[0] >= 6'h28)
      else $error("done gap 0");
   AST_DONE_GAP1: assert property (conversion_done_irq[1] |-> gap_r[1] >= 6'h28)
      else $error("done gap 1");
   AST_CH_HOLD: assert property (ana_sample[1] && $past(ana_sample[1]) && !wacc_r |-> $stable(ana_ch_sel[1]))
      else $error("channel moved");
   AST_DET_DONE: assert property (voltage_detect_irq[0] |-> conversion_done_irq[0] || ana_sample[0])
      else $error("detect without done");
   AST_RES_HIGH: assert property (pready && !pwrite && paddr[11:9] == 3'h4 && paddr[7:6] == 2'h1
      |-> prdata[31:10] == 22'h0)
      else $error("result high bits");
   AST_BUSY_SAMP: assert property (pready && !pwrite && paddr == 12'h800 && $past(ana_sample[0])
      |-> !prdata[14])
      else $error("busy while sampling");
   AST_TIME_MASK: assert property (pready && !pwrite && paddr == 12'h808 |-> (prdata & 32'hFFFF_F8FF) == 32'h0)
      else $error("time register extra bits");
endmodule
bind adcst_top adcst_chk chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ana_ch_sel(ana_ch_sel), .ana_sample(ana_sample), .conversion_done_irq(conversion_done_irq),
   .voltage_detect_irq(voltage_detect_irq));

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import adcst_pkg::*;
   logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [5:0] tcmp;
   logic [1:0] tovf, ext, cmp, smp_q, smp, done, det;
   logic [1:0][2:0] chs;
   logic [1:0][9:0] dac;
   logic [15:0] rd, cur;
   logic [2:0] chq [2][$];
   int n_mismatch, n_checks, cyc, base;
   int nd [2], ndt [2], tst [2], tdn [2];
   int clk_n [7] = '{344, 248, 176, 128, 104, 80, 56};
   adcst_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_compare_event(tcmp), .timer_overflow_event(tovf), .ext_trig_pin(ext), .ana_cmp_in(cmp),
      .ana_ch_sel(chs), .ana_sample(smp), .dac_code(dac), .conversion_done_irq(done),
      .voltage_detect_irq(det));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      cyc++;
      for (int k = 0; k < 2; k++) begin
         if (smp[k] && !smp_q[k]) begin
            tst[k] = cyc;
            chq[k].push_back(chs[k]);
         end
         if (done[k] === 1'b1) begin
            tdn[k] = cyc;
            nd[k]++;
         end
         if (det[k] === 1'b1) begin
            ndt[k]++;
         end
      end
      smp_q = smp;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic ck(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Index to byte address
   function automatic logic [11:0] ba(input logic [31:0] ofs);
      return {ofs[9:0], 2'b00};
   endfunction
   task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [1:0] s);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      pstrb <= {2'b00, s};
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) ck("ready", 16'h0000, 16'h0001);
      rd = prdata[15:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [31:0] ofs, input logic [15:0] d);
      xfer(1'b1, ba(ofs), d, 2'b11);
   endtask
   task automatic rck(input string nm, input logic [31:0] ofs, input logic [15:0] exp);
      xfer(1'b0, ba(ofs), 16'h0000, 2'b00);
      ck(nm, rd, exp);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wait_done(input int k, input int want);
      int n = 0;
      while (nd[k] < want && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      ck("done_count", 16'(nd[k]), 16'(want));
   endtask
   // Enable cleared in a separate access
   task automatic set_mode(input logic [15:0] m);
      wr(OFS_SCAN0, cur & 16'h7FFF);
      wr(OFS_SCAN0, m & 16'h7FFF);
      wr(OFS_SCAN0, m);
      cur = m;
   endtask
   task automatic trig_ck(input logic [7:0] ts, input logic [5:0] c, input logic [1:0] o, input int exp);
      wr(OFS_TSEL_A, {8'h00, ts});
      base = nd[0];
      tcmp <= c;
      tovf <= o;
      @(posedge sys_clk);
      tcmp <= 6'h00;
      tovf <= 2'b00;
      cycles(120);
      ck("trig", 16'(nd[0] - base), 16'(exp));
   endtask
   task automatic abort_ck(input logic [31:0] ofs, input logic [15:0] d, input int exp);
      base = nd[0];
      wr(OFS_SCAN0, 16'h9001);
      cycles(30);
      wr(ofs, d);
      cycles(400);
      ck("abort", 16'(nd[0] - base), 16'(exp));
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      finish_test();
   end
   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata, pstrb, tcmp, tovf, ext, cmp, cur} <= '0;
      cycles(5);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rck("scan0", OFS_SCAN0, 16'h0000);
      rck("time1", OFS_TIME1, 16'h0000);
      rck("det0", OFS_DET0, 16'h0000);
      wr(OFS_TIME0, 16'hFFFF);
      rck("time0", OFS_TIME0, 16'h0700);
      xfer(1'b1, ba(OFS_TIME0), 16'h0000, 2'b01);
      rck("time0_lo", OFS_TIME0, 16'h0700);
      xfer(1'b1, ba(OFS_SCAN0), 16'h7FFF, 2'b01);
      rck("scan0_lo", OFS_SCAN0, 16'h00FF);
      xfer(1'b1, ba(OFS_SCAN0), 16'h7FFF, 2'b10);
      rck("scan0_hi", OFS_SCAN0, 16'h1FFF);
      wr(OFS_DET0, 16'h2BCD);
      xfer(1'b1, ba(OFS_DET0), 16'h5500, 2'b10);
      rck("det0_hi", OFS_DET0, 16'h55CD);
      wr(OFS_DET0, 16'h0000);
      wr(OFS_TSEL_B, 16'h00FF);
      rck("tsel_b", OFS_TSEL_B, 16'h0033);
      xfer(1'b0, 12'hFFC, 16'h0000, 2'b00);
      ck("unmapped", {15'h0, err}, 16'h0001);
      $display("registers done");
      cmp <= 2'b11;
      for (int c = 0; c < 7; c++) begin
         wr(OFS_TIME0, 16'(c << 8));
         base = nd[0];
         wr(OFS_SCAN0, 16'h9000 | 16'(c % 6));
         if (c == 0) begin
            rck("busy_samp", OFS_SCAN0, 16'h9000);
            cycles(20);
            rck("busy_conv", OFS_SCAN0, 16'hD000);
         end
         wait_done(0, base + 1);
         ck("clocks", 16'(tdn[0] - tst[0]), 16'(clk_n[c]));
         ck("dac", 16'(dac[0]), 16'h03FF);
         ck("sel_ch", 16'(chq[0][$]), 16'(c % 6));
         rck("result", OFS_RES0 + 32'(2 * (c % 6)), 16'h03FF);
      end
      rck("idle", OFS_SCAN0, 16'h9000);
      $display("conversion time done");
      wr(OFS_TIME1, 16'h0600);
      base = nd[1];
      wr(OFS_SCAN1, 16'h8025);
      wait_done(1, base + 1);
      cycles(100);
      ck("scan_len", 16'(chq[1].size()), 16'h0004);
      for (int i = 0; i < 4; i++) begin
         ck("scan_order", 16'(chq[1][i]), 16'(i + 2));
         rck("scan_res", OFS_RES1 + 32'(2 * (i + 2)), 16'h03FF);
      end
      rck("unscanned", OFS_RES1 + 32'd12, 16'h0000);
      chq[1].delete();
      wr(OFS_SCAN1, 16'h9057);
      wait_done(1, base + 2);
      ck("sel_first", 16'(chq[1][0]), 16'h0007);
      $display("scan done");
      wr(OFS_TIME0, 16'h0000);
      abort_ck(OFS_TIME0, 16'h0000, 0);
      rck("abort_idle", OFS_SCAN0, 16'h9001);
      abort_ck(OFS_DET0, 16'h0000, 0);
      abort_ck(OFS_SCAN0, 16'h9002, 1);
      ck("restart_ch", 16'(chq[0][$]), 16'h0002);
      cur = 16'h9002;
      $display("abort done");
      wr(OFS_TIME0, 16'h0600);
      set_mode(16'h9201);
      trig_ck(8'h00, 6'h08, 2'b00, 0);
      trig_ck(8'h00, 6'h01, 2'b00, 1);
      trig_ck(8'h01, 6'h08, 2'b00, 1);
      trig_ck(8'h02, 6'h00, 2'b01, 1);
      trig_ck(8'h02, 6'h01, 2'b00, 0);
      set_mode(16'h9101);
      base = nd[0];
      ext <= 2'b01;
      cycles(120);
      ck("ext", 16'(nd[0] - base), 16'h0001);
      ext <= 2'b00;
      set_mode(16'h9801);
      base = nd[0];
      cycles(300);
      ck("poll", 16'(nd[0] - base >= 3), 16'h0001);
      set_mode(16'h1001);
      $display("triggers done");
      for (int i = 0; i < 2; i++) begin
         wr(OFS_DET0, i == 0 ? 16'hC500 : 16'h8500);
         base = ndt[0];
         set_mode(16'h9001);
         cycles(120);
         ck("detect", 16'(ndt[0] - base), 16'(1 - i));
      end
      $display("detect done");
      finish_test();
   end
endmodule
